// ---- speech_test_port_map.vh ----
`ifndef SPEECH_TEST_PORT_MAP_VH
`define SPEECH_TEST_PORT_MAP_VH

// Sample word width in bits, sent most significant bit first.
`define STP_WORD_BITS     13
// Bit counter width and its terminal count.
`define STP_CNT_W         4
`define STP_CNT_ZERO      4'h0
`define STP_CNT_ONE       4'h1
`define STP_CNT_LAST      4'hd
// Index of the most significant sample bit.
`define STP_MSB           12

// System clock rate and bit clock rate in hertz.
`define STP_SYS_HZ        50000000
`define STP_BIT_HZ        104000
// Phase accumulator: one half-period event per wrap, so the bit clock
// averages exactly the nominal rate; jitter is one system cycle.
`define STP_ACC_W         17
`define STP_ACC_MOD       17'h186a0
`define STP_ACC_INC       17'h01a0
`define STP_ACC_ZERO      17'h00000

// Test control line encodings {line 1, line 2}.
`define STP_MODE_NORMAL   2'h0
`define STP_MODE_DOWNLINK 2'h1
`define STP_MODE_UPLINK   2'h2
`define STP_MODE_ACOUSTIC 2'h3

// Synchroniser bit positions.
`define STP_SYNC_W        4
`define STP_SYNC_CTRL1    0
`define STP_SYNC_CTRL2    1
`define STP_SYNC_RESET    2
`define STP_SYNC_DATA     3
`define STP_SYNC_INIT     4'hf

`endif

// ---- speech_test_sync.v ----
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for a group of unrelated level inputs.
module speech_test_sync #(
    parameter                 WIDTH = 1,
    parameter [WIDTH-1:0]     INIT  = {WIDTH{1'b0}}
) (
    // Clock and reset.
    input  wire               clk_i,
    input  wire               rst_i,
    // Asynchronous levels in, synchronised levels out.
    input  wire [WIDTH-1:0]   async_i,
    output reg  [WIDTH-1:0]   sync_o
);

    reg [WIDTH-1:0] meta_q;   // First stage, read only by the second.

    // Both stages reset to the idle level of the lines.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= INIT;
            sync_o <= INIT;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ---- speech_test_port.v ----
`timescale 1ns/1ps
`default_nettype none
`include "speech_test_port_map.vh"

module speech_test_port #(
    // Mode command method: 0 uses control lines, 1 uses messages.
    parameter                       MODE_FROM_MESSAGE = 0
) (
    // Clock and reset.
    input  wire                     CLK_I,
    input  wire                     RST_I,
    // Tester-driven pins.
    input  wire                     TEST_CTRL1_I,
    input  wire                     TEST_CTRL2_I,
    input  wire                     TESTER_RESET_N_I,
    input  wire                     TESTER_DATA_I,
    // Device-driven pins.
    output reg                      BIT_CLK_O,
    output reg                      DEVICE_DATA_O,
    // Over-air test mode message.
    input  wire                     MSG_MODE_VALID_I,
    input  wire [1:0]               MSG_MODE_I,
    // Speech path: samples toward encoder or converter.
    input  wire                     SAMPLE_REQ_I,
    output reg  [`STP_MSB:0]        RX_SAMPLE_O,
    output reg                      RX_VALID_O,
    // Speech path: samples from decoder or converter.
    input  wire                     TX_VALID_I,
    input  wire [`STP_MSB:0]        TX_SAMPLE_I,
    // Mode and reset controls toward the speech functions.
    output reg  [1:0]               TEST_MODE_O,
    output reg                      CONVERTER_RESET_O,
    output reg                      TRANSCODER_RESET_O
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    localparam [2:0] ST_IDLE = 3'h1;   // Clock high, no frame.
    localparam [2:0] ST_HIGH = 3'h2;   // Clock high inside a frame.
    localparam [2:0] ST_LOW  = 3'h4;   // Clock low inside a frame.

    wire [`STP_SYNC_W-1:0]   pins_s;       // Synchronised pin levels.
    wire                     reset_n_s;    // Synchronised tester reset.
    wire                     data_s;       // Synchronised tester data.
    wire [1:0]               pin_mode;     // Mode from control lines.
    reg  [1:0]               msg_mode_q;   // Mode from last message.
    wire [1:0]               mode;         // Mode in force.
    wire                     test_on;      // Any test mode selected.
    reg                      reset_n_q;    // Reset level one cycle ago.
    wire                     release_ev;   // Reset trailing edge.
    reg                      armed_q;      // Test started by a release.
    reg  [`STP_ACC_W-1:0]    acc_q;        // Bit clock phase.
    wire [`STP_ACC_W-1:0]    acc_sum;      // Phase plus increment.
    wire                     tick;         // Half-period event.
    reg  [2:0]               state_q;      // Frame state.
    reg  [`STP_CNT_W-1:0]    cnt_q;        // Bits done in the frame.
    reg  [`STP_MSB:0]        tx_sh_q;      // Outgoing shift register.
    reg  [`STP_MSB:0]        rx_sh_q;      // Incoming shift register.
    reg  [`STP_MSB:0]        tx_buf_q;     // Sample waiting to go out.
    reg                      tx_pend_q;    // Outgoing sample waiting.
    reg                      req_pend_q;   // Input sample requested.
    wire                     want_frame;   // Frame may start now.
    wire                     rx_used;      // Mode delivers input data.

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    speech_test_sync #(
        .WIDTH (`STP_SYNC_W),
        .INIT  (`STP_SYNC_INIT)
    ) u_sync (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .async_i ({TESTER_DATA_I, TESTER_RESET_N_I,
                   TEST_CTRL2_I, TEST_CTRL1_I}),
        .sync_o  (pins_s)
    );

    assign reset_n_s = pins_s[`STP_SYNC_RESET];
    assign data_s    = pins_s[`STP_SYNC_DATA];

    ////////////////////////////////////////////////////////////////////////
    // Mode selection.
    // control line decode
    assign pin_mode = {pins_s[`STP_SYNC_CTRL1], pins_s[`STP_SYNC_CTRL2]};

    assign mode    = (MODE_FROM_MESSAGE != 0) ? msg_mode_q : pin_mode;
    assign test_on = (mode != `STP_MODE_NORMAL);

    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            msg_mode_q <= `STP_MODE_NORMAL;
        end else if (MSG_MODE_VALID_I) begin
            msg_mode_q <= MSG_MODE_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tester reset handling.
    // The tester holds the mode for over a second before resetting; a release
    // in a test mode arms the test, and its frames follow the current mode.
    // reset follows mode
    assign release_ev = reset_n_s & ~reset_n_q;

    // Reset level tracking, arming and reset outputs.
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            reset_n_q          <= 1'b1;
            armed_q            <= 1'b0;
            CONVERTER_RESET_O  <= 1'b0;
            TRANSCODER_RESET_O <= 1'b0;
            TEST_MODE_O        <= `STP_MODE_NORMAL;
        end else begin
            reset_n_q   <= reset_n_s;
            TEST_MODE_O <= mode;
            CONVERTER_RESET_O <= ~reset_n_s;
            TRANSCODER_RESET_O <= ~reset_n_s | (release_ev & test_on);
            if (!reset_n_s || !test_on) begin
                // Asserted reset or normal mode stops the test.
                armed_q <= 1'b0;
            end else if (release_ev) begin
                armed_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit clock rate generator.
    // nominal rate divider
    assign acc_sum = acc_q + `STP_ACC_INC;
    assign tick    = (acc_sum >= `STP_ACC_MOD);

    // Free-running phase accumulator; frames align to its events.
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            acc_q <= `STP_ACC_ZERO;
        end else if (tick) begin
            acc_q <= acc_sum - `STP_ACC_MOD;
        end else begin
            acc_q <= acc_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample hand-off with the speech functions.
    // uplink waits for request
    assign want_frame = armed_q &&
        ((mode == `STP_MODE_DOWNLINK) ? tx_pend_q : req_pend_q);
    assign rx_used = (mode == `STP_MODE_UPLINK) ||
                     (mode == `STP_MODE_ACOUSTIC);

    // Pending flags; a new event wins over the clear at frame start.
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tx_buf_q   <= {`STP_WORD_BITS{1'b0}};
            tx_pend_q  <= 1'b0;
            req_pend_q <= 1'b0;
        end else if (!armed_q) begin
            tx_pend_q  <= 1'b0;
            req_pend_q <= 1'b0;
        end else begin
            if (TX_VALID_I) begin
                tx_buf_q  <= TX_SAMPLE_I;
                tx_pend_q <= 1'b1;
            end else if (state_q == ST_IDLE && want_frame && tick) begin
                tx_pend_q <= 1'b0;
            end
            if (SAMPLE_REQ_I) begin
                req_pend_q <= 1'b1;
            end else if (state_q == ST_IDLE && want_frame && tick) begin
                req_pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial frame engine: 13 clock pulses per sample, both directions.
    // thirteen bits per word
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q       <= ST_IDLE;
            cnt_q         <= `STP_CNT_ZERO;
            tx_sh_q       <= {`STP_WORD_BITS{1'b0}};
            rx_sh_q       <= {`STP_WORD_BITS{1'b0}};
            BIT_CLK_O     <= 1'b1;
            DEVICE_DATA_O <= 1'b1;
            RX_SAMPLE_O   <= {`STP_WORD_BITS{1'b0}};
            RX_VALID_O    <= 1'b0;
        end else begin
            RX_VALID_O <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    BIT_CLK_O <= 1'b1;
                    cnt_q     <= `STP_CNT_ZERO;
                    if (want_frame && tick) begin
                        // First falling edge carries the first bit.
                        tx_sh_q <= (mode == `STP_MODE_DOWNLINK ||
                                    tx_pend_q) ? tx_buf_q :
                                   {`STP_WORD_BITS{1'b0}};
                        state_q <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (!armed_q) begin
                        // Test stopped: abandon the frame, clock high.
                        state_q <= ST_IDLE;
                    end else if (tick) begin
                        BIT_CLK_O     <= 1'b0;
                        DEVICE_DATA_O <= tx_sh_q[`STP_MSB];
                        tx_sh_q       <= {tx_sh_q[`STP_MSB-1:0], 1'b0};
                        state_q       <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (!armed_q) begin
                        BIT_CLK_O <= 1'b1;
                        state_q   <= ST_IDLE;
                    end else if (tick) begin
                        BIT_CLK_O <= 1'b1;
                        rx_sh_q   <= {rx_sh_q[`STP_MSB-1:0], data_s};
                        cnt_q     <= cnt_q + `STP_CNT_ONE;
                        if (cnt_q == `STP_CNT_LAST - `STP_CNT_ONE) begin
                            // Last bit: hand the word over if used.
                            RX_SAMPLE_O <= {rx_sh_q[`STP_MSB-1:0], data_s};
                            RX_VALID_O  <= rx_used;
                            state_q     <= ST_IDLE;
                        end else begin
                            state_q <= ST_HIGH;
                        end
                    end
                end
                default: begin
                    BIT_CLK_O <= 1'b1;
                    state_q   <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- speech_test_port_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches the link pins and reset outputs of the speech test port.
module speech_test_port_assertions (
    // Clock and reset.
    input wire logic        CLK_I,
    input wire logic        RST_I,
    // Tester side.
    input wire logic        TEST_CTRL1_I,
    input wire logic        TEST_CTRL2_I,
    input wire logic        TESTER_RESET_N_I,
    // Device side.
    input wire logic        BIT_CLK_O,
    input wire logic        DEVICE_DATA_O,
    input wire logic        RX_VALID_O,
    input wire logic [1:0]  TEST_MODE_O,
    input wire logic        CONVERTER_RESET_O,
    input wire logic        TRANSCODER_RESET_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic [15:0] lo_q;   // Cycles the bit clock has been low.
    logic [15:0] hi_q;   // Cycles the bit clock has been high.
    logic [4:0]  fall_q; // Falling edges in the current frame.
    logic [3:0]  up_q;   // Cycles since reset, saturating.
    // A long high gap marks the end of a frame.
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            lo_q <= 16'h0000;
            hi_q <= 16'h0000;
            fall_q <= 5'h00;
            up_q <= 4'h0;
        end else begin
            up_q <= (up_q == 4'hf) ? up_q : up_q + 4'h1;
            lo_q <= BIT_CLK_O ? 16'h0000 : lo_q + 16'h0001;
            hi_q <= !BIT_CLK_O ? 16'h0000 :
                    (hi_q == 16'hffff) ? hi_q : hi_q + 16'h0001;
            if (hi_q == 16'h012c) begin
                fall_q <= 5'h00;
            end else if ($fell(BIT_CLK_O)) begin
                fall_q <= fall_q + 5'h01;
            end
        end
    end
    AST_IDLE_NORMAL: assert property (
        (TEST_MODE_O == 2'h0)[*3] |-> BIT_CLK_O)
        else $error("bit clock runs in normal mode");
    AST_DATA_HOLD: assert property (
        !$past(BIT_CLK_O) |-> $stable(DEVICE_DATA_O))
        else $error("data moved while clock low or at rise");
    AST_LOW_TIME: assert property (
        $rose(BIT_CLK_O) |-> lo_q >= 16'h00f0 && lo_q <= 16'h00f1)
        else $error("bit clock low time wrong");
    AST_HIGH_GAP: assert property (
        $fell(BIT_CLK_O) |-> hi_q >= 16'h00f0)
        else $error("bit clock high time too short");
    AST_WORD_BITS: assert property (
        $rose(BIT_CLK_O) |-> fall_q <= 5'h0d)
        else $error("more than thirteen bits in a frame");
    AST_RX_PULSE: assert property (
        RX_VALID_O |-> TEST_MODE_O[1] ##1 !RX_VALID_O)
        else $error("receive pulse wrong mode or too long");
    AST_RX_AFTER_WORD: assert property (
        $rose(BIT_CLK_O) && fall_q == 5'h0d && TEST_MODE_O[1]
        |-> RX_VALID_O)
        else $error("no receive pulse after last bit");
    AST_CONV_RESET: assert property (
        (!TESTER_RESET_N_I)[*4] |-> CONVERTER_RESET_O && TRANSCODER_RESET_O)
        else $error("tester reset not passed on");
    AST_TRANS_TAIL: assert property (
        $fell(CONVERTER_RESET_O) && TEST_MODE_O != 2'h0
        |-> TRANSCODER_RESET_O ##1 !TRANSCODER_RESET_O)
        else $error("transcoder reset tail wrong");
    AST_MODE_MAP: assert property (
        ($stable({TEST_CTRL1_I, TEST_CTRL2_I}) && up_q == 4'hf)[*6]
        |-> TEST_MODE_O == {TEST_CTRL1_I, TEST_CTRL2_I})
        else $error("mode does not follow control lines");
endmodule
bind speech_test_port speech_test_port_assertions u_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .TEST_CTRL1_I(TEST_CTRL1_I),
    .TEST_CTRL2_I(TEST_CTRL2_I), .TESTER_RESET_N_I(TESTER_RESET_N_I),
    .BIT_CLK_O(BIT_CLK_O), .DEVICE_DATA_O(DEVICE_DATA_O),
    .RX_VALID_O(RX_VALID_O), .TEST_MODE_O(TEST_MODE_O),
    .CONVERTER_RESET_O(CONVERTER_RESET_O),
    .TRANSCODER_RESET_O(TRANSCODER_RESET_O));
`default_nettype wire

// ---- tester_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Tester end of the link: one word out and one word in per frame.
module tester_model (
    // Link pins.
    input  wire logic        bit_clk_i,
    input  wire logic        dev_data_i,
    output logic             tst_data_o,
    // Word to send, last word received, frames seen.
    input  wire logic [12:0] word_i,
    output logic [12:0]      got_o,
    output logic [7:0]       fr_o
);
    logic [12:0] sh;   // Outgoing shift register.
    logic [3:0]  cnt;  // Bits sampled this frame.
    logic        busy; // Set from the first fall to the last rise.
    initial begin
        tst_data_o = 1'b0;
        got_o = 13'h0000;
        fr_o = 8'h00;
        busy = 1'b0;
    end
    always @(negedge bit_clk_i) begin
        if (!busy) begin
            sh = word_i;
            cnt = 4'h0;
            busy = 1'b1;
        end
        tst_data_o = sh[12];
        sh = {sh[11:0], 1'b0};
    end
    // sample on rise, release after hold time
    always @(posedge bit_clk_i) begin
        if (busy) begin
            got_o = {got_o[11:0], dev_data_i};
            cnt = cnt + 4'h1;
            if (cnt == 4'hd) begin
                busy = 1'b0;
                fr_o = fr_o + 8'h01;
                #1000 tst_data_o = ~tst_data_o;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// Drives each test mode with corner and random words; downlink checks only the device word, uplink and acoustic check both.
module testbench;
    logic        clk, rst, ctrl1, ctrl2, rstn, req, txv, bclk, ddat;
    logic        tdat, rxv, conv_rst, tc_rst, mv;
    logic [12:0] txs, tw, got, rxs, rx_word;
    logic [1:0]  mode, mm;
    logic [7:0]  fr, f0;
    logic [31:0] seed = 32'h0000004b;
    int          error_cnt, n_compared, rx_seen, falls, k, r0, r1;
    bit          hung;   // Set once a bounded wait has run out.
    speech_test_port DUT (.CLK_I(clk), .RST_I(rst), .TEST_CTRL1_I(ctrl1),
        .TEST_CTRL2_I(ctrl2), .TESTER_RESET_N_I(rstn), .TESTER_DATA_I(tdat),
        .BIT_CLK_O(bclk), .DEVICE_DATA_O(ddat), .MSG_MODE_VALID_I(mv),
        .MSG_MODE_I(mm), .SAMPLE_REQ_I(req), .RX_SAMPLE_O(rxs),
        .RX_VALID_O(rxv), .TX_VALID_I(txv), .TX_SAMPLE_I(txs),
        .TEST_MODE_O(mode), .CONVERTER_RESET_O(conv_rst),
        .TRANSCODER_RESET_O(tc_rst));
    tester_model tester (.bit_clk_i(bclk), .dev_data_i(ddat),
        .tst_data_o(tdat), .word_i(tw), .got_o(got), .fr_o(fr));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Latches each received word, counts bit clock falls.
    always @(posedge clk) if (rxv === 1'b1) begin
        rx_seen <= rx_seen + 1;
        rx_word <= rxs;
    end
    always @(negedge bclk) falls++;
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Uplink sends nothing pending, so the outgoing word is zero.
    function automatic logic [12:0] exp_out(input logic [1:0] m,
                                            input logic [12:0] w);
        return (m == 2'h2) ? 13'h0000 : w;
    endfunction
    task automatic chk(input logic [12:0] s, input logic [12:0] e);
        n_compared++;
        if (s !== e) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
            error_cnt++;
        end
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Sets the mode lines, then pulses the tester reset.
    task automatic start(input logic [1:0] m);
        // mode lines first, reset pulse after
        @(posedge clk);
        {ctrl1, ctrl2} <= m;
        repeat (10) @(posedge clk);
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(negedge clk);
        chk({11'h000, mode}, {11'h000, m});
        // A message for another mode must not move the pin-set mode.
        @(posedge clk);
        mm <= ~m;
        mv <= 1'b1;
        @(posedge clk);
        mv <= 1'b0;
        repeat (4) @(negedge clk);
        chk({11'h000, mode}, {11'h000, m});
    endtask
    // One word each way; waits for the frame under a bound.
    task automatic xfer(input logic [1:0] m, input logic [12:0] w, t);
        f0 = fr;
        r0 = rx_seen;
        @(posedge clk);
        tw <= t;
        txs <= w;
        txv <= (m != 2'h2);
        req <= m[1];
        @(posedge clk);
        txv <= 1'b0;
        req <= 1'b0;
        k = 0;
        while (fr == f0 && k < 9000) begin @(posedge clk); k++; end
        while (m[1] && rx_seen == r0 && k < 9000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 9000) begin
            // A hung frame counts once and skips the rest of the run.
            error_cnt++;
            hung = 1'b1;
        end else begin
            chk(got, exp_out(m, w));
            if (m[1]) chk(rx_word, t);
        end
    endtask
    initial begin
        rst = 1'b1;
        {ctrl1, ctrl2, req, txv} = 4'h0;
        mv = 1'b0;
        mm = 2'h0;
        hung = 1'b0;
        rstn = 1'b1;
        txs = 13'h0000;
        tw = 13'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({12'h000, bclk}, 13'h0001);
        for (int m = 1; m < 4 && !hung; m++) begin
            start(m[1:0]);
            xfer(m[1:0], 13'h1000, 13'h0fff);
            seed = next_rand(seed);
            if (!hung) xfer(m[1:0], seed[12:0], seed[28:16]);
            $display("test mode %0d done", m);
        end
        if (!hung) begin
            // Normal mode: requests and samples must start no frame.
            start(2'h0);
            r0 = falls;
            r1 = rx_seen;
            @(posedge clk);
            tw <= 13'h0555;
            txs <= 13'h0aaa;
            txv <= 1'b1;
            req <= 1'b1;
            @(posedge clk);
            txv <= 1'b0;
            req <= 1'b0;
            repeat (7000) @(posedge clk);
            chk(13'(falls - r0), 13'h0000);
            chk(13'(rx_seen - r1), 13'h0000);
            $display("test normal mode done");
        end
        summarize();
    end
endmodule
`default_nettype wire
